/* design/acs_defines.svh */
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH
`define ACS_OFF_CTRL1 8'h00
`define ACS_OFF_CTRL2 8'h04
`define ACS_OFF_CTRL3 8'h08
`define ACS_OFF_CTRL4 8'h0c
`define ACS_OFF_CH123 8'h10
`define ACS_OFF_CH0 8'h14
`define ACS_OFF_SCAN 8'h18
`define ACS_OFF_PIN_DIGITAL_SELECT 8'h1c
`define ACS_MASK_CTRL1 16'h1400
`define ACS_MASK_CTRL2 16'he73f
`define ACS_MASK_CTRL3 16'h9fff
`define ACS_MASK_CTRL4 16'h0007
`define ACS_MASK_CH123 16'h0707
`define ACS_MASK_CH0 16'h9f9f
`define ACS_MASK_PIN13 16'h1fff
`define ACS_RESET16 16'h0000
`define ACS_BIT_ORDER 12
`define ACS_BIT_12B 10
`define ACS_BIT_SCAN 10
`define ACS_BIT_FILL 7
`define ACS_BIT_SPLIT 1
`define ACS_BIT_ALT 0
`define ACS_BIT_RC 15
`define ACS_F_CHANNEL_COUNT_SELECT 9:8
`define ACS_F_CONVERSIONS_PER_INTERRUPT 5:2
`define ACS_F_AUTO_SAMPLE_TIME 12:8
`define ACS_F_CONV_CLOCK_DIVIDE 7:0
`define ACS_F_DMA_WORDS_PER_INPUT 2:0
`define ACS_F_CH0_POS_SELECT_A 4:0
`define ACS_F_CH0_POS_SELECT_B 12:8
`define ACS_BIT_CH0_NEG_SELECT_A 7
`define ACS_BIT_CH0_NEG_SELECT_B 15
`define ACS_BIT_CH123_POS_SELECT_A 0
`define ACS_F_CH123_NEG_SELECT_A 2:1
`define ACS_BIT_CH123_POS_SELECT_B 8
`define ACS_F_CH123_NEG_SELECT_B 10:9
`define ACS_DIV_MAX 8'h3f
`define ACS_HALF_BASE 4'h8
`define ACS_RESP_OKAY 2'b00
`define ACS_RESP_SLVERR 2'b10
`endif

/* design/acs_pkg.sv */
`default_nettype none
package acs_pkg;
  typedef struct packed {
    logic neg;
    logic [4:0] pos;
  } acs_ch0_sel_t;
  typedef struct packed {
    logic [1:0] neg;
    logic pos;
  } acs_ch123_sel_t;
  typedef enum logic {samp_idle, samp_count} acs_samp_state_t;
endpackage : acs_pkg
`default_nettype wire

/* design/acs_tick_gen.sv */
`include "acs_defines.svh"
`default_nettype none
module acs_tick_gen (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic use_rc, // Take ticks from the RC clock.
  input wire logic rc_edge, // Synchronised RC clock rising edge.
  input wire logic [7:0] divide, // Divide field.
  output logic tick // One pulse per conversion clock period.
);
  logic [7:0] cnt;
  logic [7:0] period;

  // Reserved divide codes are clamped so the clock never runs slower than intended.
  assign period = (divide > `ACS_DIV_MAX) ? `ACS_DIV_MAX : divide;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end
    else if (use_rc)
    begin
      cnt <= 8'h00;
      tick <= rc_edge;
    end
    else if (cnt >= period)
    begin
      cnt <= 8'h00;
      tick <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 8'h01;
      tick <= 1'b0;
    end
  end
endmodule : acs_tick_gen
`default_nettype wire

/* design/acs_sequencer.sv */
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`include "acs_defines.svh"
`default_nettype none
module acs_sequencer #(
  parameter int NUM_INPUTS = 13,
  parameter logic [12:0] PIN_PRESENT = 13'h1fff
) (
  input wire logic aclk, // System clock, 125 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] awaddr, // Write address.
  input wire logic awvalid, // Write address valid.
  output logic awready, // Write address ready.
  input wire logic [31:0] wdata, // Write data.
  input wire logic [3:0] wstrb, // Write byte strobes.
  input wire logic wvalid, // Write data valid.
  output logic wready, // Write data ready.
  output logic [1:0] bresp, // Write response.
  output logic bvalid, // Write response valid.
  input wire logic bready, // Write response ready.
  input wire logic [7:0] araddr, // Read address.
  input wire logic arvalid, // Read address valid.
  output logic arready, // Read address ready.
  output logic [31:0] rdata, // Read data.
  output logic [1:0] rresp, // Read response.
  output logic rvalid, // Read data valid.
  input wire logic rready, // Read data ready.
  input wire logic conv_done, // Core finished one sample/conversion.
  input wire logic sample_start, // Core began sampling.
  input wire logic rc_clock_pin, // Internal RC clock, asynchronous.
  input wire logic converter_module_disable, // Converter powered off.
  output logic conv_clock_tick, // Conversion clock period pulse.
  output logic sample_end, // Auto-sample time elapsed.
  output logic sample_b_active, // Next sample uses B selects.
  output logic [1:0] channel_count, // Active sample/hold channels.
  output acs_pkg::acs_ch0_sel_t ch0_select, // Channel 0 mux selects.
  output acs_pkg::acs_ch123_sel_t ch123_select, // Channel 1-3 mux selects.
  output logic select_low_reference, // Convert low reference instead.
  output logic [3:0] buffer_addr, // Result buffer location.
  output logic [10:0] dma_addr, // DMA address offered.
  output logic dma_advance, // DMA address advances.
  output logic conv_event, // Conversion interrupt event.
  output logic [12:0] pin_digital // Pin digital, mux grounded.
);
  logic [15:0] ctrl1, ctrl2, ctrl3, ctrl4, ch123, ch0, scan, pin_digital_select;
  logic fill_half;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_full, w_full;
  logic [31:0] rd_word;
  logic rc_meta, rc_sync, rc_last;
  logic [3:0] scan_ptr;
  logic [3:0] conv_cnt;
  logic [6:0] dma_ptr;
  logic [4:0] samp_cnt;
  acs_pkg::acs_samp_state_t samp_state;
  logic twelve;
  logic scan_on;
  logic [2:0] dma_shift;
  logic [6:0] dma_mask;
  logic [15:0] rd_ctrl2;
  logic [15:0] rd_ch123;

  assign twelve = ctrl1[`ACS_BIT_12B];
  assign scan_on = ctrl2[`ACS_BIT_SCAN];

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      `ACS_OFF_CTRL1, `ACS_OFF_CTRL2, `ACS_OFF_CTRL3, `ACS_OFF_CTRL4,
      `ACS_OFF_CH123, `ACS_OFF_CH0, `ACS_OFF_SCAN, `ACS_OFF_PIN_DIGITAL_SELECT: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction : addr_mapped

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [15:0] m);
    logic [15:0] lanes;
    lanes = {{8{s[1]}}, {8{s[0]}}};
    merge = ((old & ~lanes) | (d[15:0] & lanes)) & m;
  endfunction : merge

  function automatic logic [3:0] next_scan(input logic [3:0] p, input logic [15:0] en);
    logic [3:0] idx;
    logic found;
    idx = p;
    found = 1'b0;
    next_scan = p;
    for (int i = 1; i <= NUM_INPUTS; i++)
    begin
      idx = (idx == 4'(NUM_INPUTS - 1)) ? 4'h0 : idx + 4'h1;
      if (!found && en[idx])
      begin
        next_scan = idx;
        found = 1'b1;
      end
    end
  endfunction : next_scan

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `ACS_RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_addr_q <= awaddr;
        aw_full <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        w_full <= 1'b1;
        wready <= 1'b0;
      end
      if (aw_full && w_full && !bvalid)
      begin
        bvalid <= 1'b1;
        bresp <= addr_mapped(aw_addr_q) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid <= 1'b0;
        aw_full <= 1'b0;
        w_full <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Writes land in the cycle the response is raised, masked to implemented bits.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl1 <= `ACS_RESET16;
      ctrl2 <= `ACS_RESET16;
      ctrl3 <= `ACS_RESET16;
      ctrl4 <= `ACS_RESET16;
      ch123 <= `ACS_RESET16;
      ch0 <= `ACS_RESET16;
      scan <= `ACS_RESET16;
      pin_digital_select <= `ACS_RESET16;
    end
    else if (aw_full && w_full && !bvalid)
    begin
      case (aw_addr_q)
        `ACS_OFF_CTRL1: ctrl1 <= merge(ctrl1, w_data_q, w_strb_q, `ACS_MASK_CTRL1);
        `ACS_OFF_CTRL2: ctrl2 <= merge(ctrl2, w_data_q, w_strb_q, `ACS_MASK_CTRL2);
        `ACS_OFF_CTRL3: ctrl3 <= merge(ctrl3, w_data_q, w_strb_q, `ACS_MASK_CTRL3);
        `ACS_OFF_CTRL4: ctrl4 <= merge(ctrl4, w_data_q, w_strb_q, `ACS_MASK_CTRL4);
        `ACS_OFF_CH123: ch123 <= merge(ch123, w_data_q, w_strb_q, `ACS_MASK_CH123);
        `ACS_OFF_CH0: ch0 <= merge(ch0, w_data_q, w_strb_q, `ACS_MASK_CH0);
        `ACS_OFF_SCAN: scan <= merge(scan, w_data_q, w_strb_q, `ACS_MASK_PIN13);
        `ACS_OFF_PIN_DIGITAL_SELECT: pin_digital_select <= merge(pin_digital_select, w_data_q, w_strb_q, `ACS_MASK_PIN13);
        default: ctrl1 <= ctrl1;
      endcase
    end
  end

  always_comb
  begin
    rd_ctrl2 = ctrl2;
    rd_ctrl2[`ACS_BIT_FILL] = fill_half;
    if (twelve)
    begin
      rd_ctrl2[`ACS_F_CHANNEL_COUNT_SELECT] = 2'b00;
    end
    rd_ch123 = twelve ? `ACS_RESET16 : ch123;
    case (araddr)
      `ACS_OFF_CTRL1: rd_word = {16'h0000, ctrl1};
      `ACS_OFF_CTRL2: rd_word = {16'h0000, rd_ctrl2};
      `ACS_OFF_CTRL3: rd_word = {16'h0000, ctrl3};
      `ACS_OFF_CTRL4: rd_word = {16'h0000, ctrl4};
      `ACS_OFF_CH123: rd_word = {16'h0000, rd_ch123};
      `ACS_OFF_CH0: rd_word = {16'h0000, ch0};
      `ACS_OFF_SCAN: rd_word = {16'h0000, scan};
      `ACS_OFF_PIN_DIGITAL_SELECT: rd_word = {16'h0000, pin_digital_select};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `ACS_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= addr_mapped(araddr) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Conversion clock and auto-sample timer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rc_meta <= 1'b0;
      rc_sync <= 1'b0;
      rc_last <= 1'b0;
    end
    else
    begin
      rc_meta <= rc_clock_pin;
      rc_sync <= rc_meta;
      rc_last <= rc_sync;
    end
  end

  acs_tick_gen u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .use_rc(ctrl3[`ACS_BIT_RC]),
    .rc_edge(rc_sync && !rc_last),
    .divide(ctrl3[`ACS_F_CONV_CLOCK_DIVIDE]),
    .tick(conv_clock_tick)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      samp_state <= acs_pkg::samp_idle;
      samp_cnt <= 5'h00;
      sample_end <= 1'b0;
    end
    else
    begin
      sample_end <= 1'b0;
      case (samp_state)
        acs_pkg::samp_idle:
        begin
          samp_cnt <= 5'h00;
          if (sample_start)
          begin
            samp_state <= acs_pkg::samp_count;
          end
        end
        acs_pkg::samp_count:
        begin
          if (samp_cnt == ctrl3[`ACS_F_AUTO_SAMPLE_TIME])
          begin
            sample_end <= 1'b1;
            samp_state <= acs_pkg::samp_idle;
          end
          else if (conv_clock_tick)
          begin
            samp_cnt <= samp_cnt + 5'h01;
          end
        end
        default: samp_state <= acs_pkg::samp_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencing and buffer addressing
  // ----------------------------------------------------------------
  assign dma_shift = (ctrl4[`ACS_F_DMA_WORDS_PER_INPUT] == 3'b000) ? 3'b001 : ctrl4[`ACS_F_DMA_WORDS_PER_INPUT];
  assign dma_mask = 7'((8'h01 << dma_shift) - 8'h01);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sample_b_active <= 1'b0;
      scan_ptr <= 4'h0;
      conv_cnt <= 4'h0;
      fill_half <= 1'b0;
      dma_ptr <= 7'h00;
      conv_event <= 1'b0;
      dma_advance <= 1'b0;
      dma_addr <= 11'h000;
    end
    else
    begin
      conv_event <= 1'b0;
      dma_advance <= 1'b0;
      if (conv_done)
      begin
        sample_b_active <= ctrl2[`ACS_BIT_ALT] ? !sample_b_active : 1'b0;
        if (scan_on && !sample_b_active)
        begin
          scan_ptr <= next_scan(scan_ptr, scan);
        end
        if (conv_cnt == ctrl2[`ACS_F_CONVERSIONS_PER_INTERRUPT])
        begin
          conv_cnt <= 4'h0;
          conv_event <= 1'b1;
          dma_advance <= 1'b1;
          dma_ptr <= (dma_ptr + 7'h01) & dma_mask;
          if (ctrl2[`ACS_BIT_SPLIT])
          begin
            fill_half <= !fill_half;
          end
          if (ctrl1[`ACS_BIT_ORDER])
          begin
            dma_addr <= {7'h00, buffer_addr};
          end
          else
          begin
            dma_addr <= 11'({7'h00, ch0_select.pos[3:0]} << dma_shift) | {4'h0, dma_ptr};
          end
        end
        else
        begin
          conv_cnt <= conv_cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ch0_select <= '0;
      ch123_select <= '0;
      select_low_reference <= 1'b0;
      buffer_addr <= 4'h0;
      channel_count <= 2'b00;
      pin_digital <= 13'h0000;
    end
    else
    begin
      if (sample_b_active)
      begin
        ch0_select.pos <= ch0[`ACS_F_CH0_POS_SELECT_B];
        ch0_select.neg <= ch0[`ACS_BIT_CH0_NEG_SELECT_B];
        ch123_select.neg <= twelve ? 2'b00 : ch123[`ACS_F_CH123_NEG_SELECT_B];
        ch123_select.pos <= twelve ? 1'b0 : ch123[`ACS_BIT_CH123_POS_SELECT_B];
      end
      else
      begin
        ch0_select.pos <= scan_on ? {1'b0, scan_ptr} : ch0[`ACS_F_CH0_POS_SELECT_A];
        ch0_select.neg <= ch0[`ACS_BIT_CH0_NEG_SELECT_A];
        ch123_select.neg <= twelve ? 2'b00 : ch123[`ACS_F_CH123_NEG_SELECT_A];
        ch123_select.pos <= twelve ? 1'b0 : ch123[`ACS_BIT_CH123_POS_SELECT_A];
      end
      select_low_reference <= scan_on && !sample_b_active && !PIN_PRESENT[scan_ptr];
      buffer_addr <= ((ctrl2[`ACS_BIT_SPLIT] && fill_half) ? `ACS_HALF_BASE : 4'h0)
                     + conv_cnt;
      channel_count <= twelve ? 2'b00 : ctrl2[`ACS_F_CHANNEL_COUNT_SELECT];
      pin_digital <= converter_module_disable ? 13'h1fff : pin_digital_select[12:0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence zero_wait_start_s;
    sample_start && samp_state == acs_pkg::samp_idle && ctrl3[`ACS_F_AUTO_SAMPLE_TIME] == 5'h00;
  endsequence
  sequence end_after_two_s;
    !sample_end ##1 sample_end;
  endsequence

  rate_event_a: assert property (conv_event |-> $past(conv_cnt) == $past(ctrl2[`ACS_F_CONVERSIONS_PER_INTERRUPT]))
    else $error("event not after the programmed conversion count");
  fill_toggle_a: assert property (conv_event && $past(ctrl2[`ACS_BIT_SPLIT])
                                  |-> fill_half != $past(fill_half))
    else $error("fill half did not toggle at the event");
  alt_off_a: assert property (conv_done && !ctrl2[`ACS_BIT_ALT] |=> !sample_b_active)
    else $error("sample B used with alternate off");
  alt_on_a: assert property (conv_done && ctrl2[`ACS_BIT_ALT]
                             |=> sample_b_active != $past(sample_b_active))
    else $error("samples did not alternate");
  pin_disable_a: assert property (converter_module_disable |=> pin_digital == 13'h1fff)
    else $error("pins not digital while disabled");
  pin_cfg_a: assert property (!converter_module_disable |=> pin_digital == $past(pin_digital_select[12:0]))
    else $error("pin mode does not follow port bits");
  twelve_chan_a: assert property (twelve |=> channel_count == 2'b00)
    else $error("channel count not zero in twelve-bit mode");
  rc_tick_a: assert property (ctrl3[`ACS_BIT_RC] && !(rc_sync && !rc_last)
                              |=> !conv_clock_tick)
    else $error("tick without an RC edge");
  samp_zero_a: assert property (zero_wait_start_s |-> ##1 end_after_two_s)
    else $error("zero sample time did not end in two cycles");
  unmapped_rd_a: assert property (arvalid && arready && !addr_mapped(araddr)
                                  |=> rvalid && rresp == `ACS_RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule : acs_sequencer
`default_nettype wire

/* dv/acs_core_model.sv */
`default_nettype none
// ----
// Converter core stand-in
// ----
module acs_core_model (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic fire, // Start one sample/conversion.
  input wire logic slow, // Take the long conversion time.
  output logic sample_start, // Sampling began.
  output logic conv_done, // Conversion finished.
  output logic rc_clock_pin // Internal RC clock.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] remain;
  // The RC oscillator runs free and unrelated to aclk, so the sequencer must resynchronise it before taking its rising edges as ticks.
  initial rc_clock_pin = 1'b0;
  always #37 rc_clock_pin = ~rc_clock_pin;
  always_ff @(posedge aclk)
  begin
    sample_start <= aresetn && fire;
    conv_done <= aresetn && remain == 4'h1;
    if (!aresetn)
      remain <= 4'h0;
    else if (fire)
      remain <= slow ? 4'h9 : 4'h3;
    else if (remain != 4'h0)
      remain <= remain - 4'h1;
  end
endmodule : acs_core_model
`default_nettype wire

/* dv/tb_adc_sequencer_config.sv */
`default_nettype none
module tb_adc_sequencer_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic fire = 1'b0;
  logic slow = 1'b0;
  logic converter_module_disable = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, conv_done, sample_start, rc_clock_pin;
  logic conv_clock_tick, sample_end, sample_b_active, dma_advance, conv_event;
  logic select_low_reference;
  logic [1:0] bresp, rresp, resp, channel_count;
  logic [31:0] rdata, rd;
  acs_pkg::acs_ch0_sel_t ch0_select;
  acs_pkg::acs_ch123_sel_t ch123_select;
  logic [3:0] buffer_addr;
  logic [10:0] dma_addr;
  logic [12:0] pin_digital;
  int n_errors = 0;
  int check_count = 0;
  int ev_count = 0;
  int adv_count = 0;
  int tick_count = 0;
  int se_count = 0;
  always #4 aclk = ~aclk;
  always @(posedge aclk)
  begin
    if (conv_event === 1'b1)
      ev_count <= ev_count + 1;
    if (dma_advance === 1'b1)
      adv_count <= adv_count + 1;
    if (conv_clock_tick === 1'b1)
      tick_count <= tick_count + 1;
    if (sample_end === 1'b1)
      se_count <= se_count + 1;
  end
  // Inputs 6 to 8 have no pin on this build, so scanning them must pick the low reference.
  acs_sequencer #(.PIN_PRESENT(13'h1e3f)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .conv_done, .sample_start, .rc_clock_pin, .converter_module_disable,
    .conv_clock_tick, .sample_end, .sample_b_active, .channel_count, .ch0_select,
    .ch123_select, .select_low_reference, .buffer_addr, .dma_addr, .dma_advance, .conv_event,
    .pin_digital);
  acs_core_model core (.aclk, .aresetn, .fire, .slow, .sample_start, .conv_done,
    .rc_clock_pin);
  // ----
  // Bus and compare helpers
  // ----
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic timed_out(input int n);
    if (n >= 200)
    begin
      n_errors++;
      $display("mismatch at %0t: wait timed out", $time);
      end_of_test();
    end
  endtask : timed_out
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      n++;
    end
    while (bvalid !== 1'b1 && n < 200);
    timed_out(n);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      n++;
    end
    while (rvalid !== 1'b1 && n < 200);
    timed_out(n);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd_reg
  task automatic conv(input logic s);
    int n;
    n = 0;
    slow <= s;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (conv_done !== 1'b1 && n < 200);
    timed_out(n);
    repeat (3) @(posedge aclk);
  endtask : conv
  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    for (int a = 0; a < 32; a += 4)
    begin
      rd_reg(a[7:0]);
      chk(rd, 32'h0, "reset value");
    end
    chk({19'h0, pin_digital}, 32'h0, "pins after reset");
  endtask : t_reset
  task automatic t_masks();
    logic [15:0] m [7];
    m = '{16'he73f, 16'h9fff, 16'h0007, 16'h0707, 16'h9f9f, 16'h1fff, 16'h1fff};
    for (int i = 0; i < 7; i++)
    begin
      wr(8'h04 + 8'(4 * i), 32'hffffffff);
      rd_reg(8'h04 + 8'(4 * i));
      chk(rd, {16'h0, m[i]}, "writable bits");
    end
    chk({19'h0, pin_digital}, 32'h1fff, "pins digital");
    chk({30'h0, channel_count}, 32'h3, "channel count");
    wr(8'h00, 32'h0400);
    rd_reg(8'h04);
    chk(rd, 32'he43f, "count field in 12-bit mode");
    rd_reg(8'h10);
    chk(rd, 32'h0, "ch123 in 12-bit mode");
    chk({29'h0, ch123_select}, 32'h0, "ch123 select in 12-bit mode");
    chk({30'h0, channel_count}, 32'h0, "one sample/hold");
    wr(8'h00, 32'h0);
    wr(8'h1c, 32'h0);
    // Disabling the converter must win over analog pin settings.
    converter_module_disable <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({19'h0, pin_digital}, 32'h1fff, "pins while disabled");
    converter_module_disable <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({19'h0, pin_digital}, 32'h0, "pins analog");
    for (int i = 0; i < 7; i++)
      wr(8'h04 + 8'(4 * i), 32'h0);
  endtask : t_masks
  task automatic t_bus_err();
    wr(8'h20, 32'h1);
    chk({30'h0, resp}, 32'h2, "unmapped write response");
    rd_reg(8'h20);
    chk({30'h0, resp}, 32'h2, "unmapped read response");
    chk(rd, 32'h0, "unmapped read data");
  endtask : t_bus_err
  task automatic t_rate();
    wr(8'h04, 32'h0008);
    ev_count = 0;
    for (int i = 1; i <= 3; i++)
    begin
      conv(i[0]);
      chk(ev_count, (i == 3) ? 32'h1 : 32'h0, "event after three");
    end
  endtask : t_rate
  task automatic t_split();
    wr(8'h04, 32'h0002);
    ev_count = 0;
    conv(1'b0);
    rd_reg(8'h04);
    chk(rd, 32'h0082, "upper half filling");
    conv(1'b1);
    rd_reg(8'h04);
    chk(rd, 32'h0002, "lower half filling");
    chk(ev_count, 32'h2, "event each conversion");
  endtask : t_split
  task automatic t_alt();
    wr(8'h14, 32'h8905);
    wr(8'h04, 32'h0000);
    conv(1'b0);
    chk({26'h0, ch0_select}, 32'h05, "sample A kept");
    wr(8'h04, 32'h0001);
    conv(1'b1);
    chk({31'h0, sample_b_active}, 32'h1, "sample B next");
    chk({26'h0, ch0_select}, 32'h29, "sample B selects");
    conv(1'b0);
    chk({26'h0, ch0_select}, 32'h05, "back to sample A");
  endtask : t_alt
  task automatic t_dma();
    int t0;
    int s0;
    int a0;
    // A reset in mid-run must clear the DMA pointer and all sequencing state.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(8'h08);
    chk(rd, 32'h0, "ctrl3 after second reset");
    wr(8'h0c, 32'h0002);
    wr(8'h14, 32'h0003);
    wr(8'h08, 32'h0202);
    repeat (3) @(posedge aclk);
    t0 = tick_count;
    repeat (30) @(posedge aclk);
    chk(tick_count - t0, 32'h0a, "tick every three cycles");
    s0 = se_count;
    a0 = adv_count;
    conv(1'b1);
    chk({21'h0, dma_addr}, 32'h00c, "scatter address first");
    conv(1'b1);
    chk({21'h0, dma_addr}, 32'h00d, "scatter address next");
    chk(se_count - s0, 32'h2, "auto-sample ends");
    chk(adv_count - a0, 32'h2, "DMA advance per event");
  endtask : t_dma
  task automatic t_scan();
    wr(8'h18, 32'h0060);
    wr(8'h04, 32'h0400);
    conv(1'b0);
    chk({26'h0, ch0_select}, 32'h05, "scan first input");
    chk({31'h0, select_low_reference}, 32'h0, "input with a pin");
    conv(1'b0);
    chk({26'h0, ch0_select}, 32'h06, "scan next input");
    chk({31'h0, select_low_reference}, 32'h1, "input without a pin");
    conv(1'b0);
    chk({26'h0, ch0_select}, 32'h05, "scan wraps");
  endtask : t_scan
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_masks();
    t_bus_err();
    t_rate();
    t_split();
    t_alt();
    t_dma();
    t_scan();
    end_of_test();
  end
endmodule : tb_adc_sequencer_config
`default_nettype wire
